// [include/cil_defs.svh]
// Opcode constants and timing figures for the instruction length and cycle decoder
`ifndef CIL_DEFS_SVH
`define CIL_DEFS_SVH
`define CIL_OP_DIV      8'h84
`define CIL_OP_MUL      8'hA4
`define CIL_OP_XMOVE_PTR_RD 8'hE0
`define CIL_OP_XMOVE_PTR_WR 8'hF0
`define CIL_MULDIV_CYC  4'h9
`define CIL_XRAM_TOP    16'h00FF
`define CIL_RST_BYTES   2'h1
`define CIL_RST_CYCLES  4'h1
`endif

// [include/cil_pkg.sv]
// Types shared by the instruction length and cycle decoder
package cil_pkg;
    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        CIL_IDLE = 2'b01,
        CIL_EXEC = 2'b10
    } cil_state_type;

    // Decoded length and duration of one opcode
    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
    } cil_info_type;

    // Whole register state of the decoder
    typedef struct packed {
        cil_state_type state;
        logic [3:0]    remain;
        logic [1:0]    bytes;
        logic [3:0]    cycles;
        logic          busy;
        logic          fetch_next;
        logic          read_latch;
        logic          xram_sel;
        logic [7:0]    xram_addr;
        logic          xram_wrap;
        logic [7:0]    acc_out;
        logic [7:0]    b_out;
        logic          excess;
        logic          muldiv_done;
    } cil_regs_type;
endpackage

// [hdl/cil_decoder.sv]
// Instruction length and cycle decoder with fetch sequencer for the core
// How it works
// - Most instructions one or two cycles, 4 MIPS
// - Register arithmetic and logic: one byte, one cycle
// - Indirect arithmetic and logic: one byte, two cycles
// - Direct or immediate accumulator ops: two bytes, two
// - Immediate logic into direct byte: three, three
// - Data pointer increment three; direct increment two
// - Accumulator clear, complement, swap, rotate: one, one
// - Indirect moves two cycles; register-accumulator moves one
// - Direct-direct and immediate-direct moves: three, three
// - Data pointer immediate load: three bytes, three
// - Code byte load: one byte, four cycles
// - Extended data moves: one byte, four cycles
// - Push and pop: two bytes, two cycles
// - Indirect exchanges two cycles; register exchange one
// - Carry ops one/one; direct bit ops two/two
// - Indirect table jump: one byte, three cycles
// - Absolute, short, carry, zero jumps: two, three
// - Bit jumps and long jump/call: three, four
// - Compare-branch-unequal forms: three bytes, four cycles
// - Decrement-branch: register two/three, direct three/four
// - Port read-modify-write reads output latch
// - Multiply: low byte accumulator, high byte second
// - Divide by zero sets excess flag
// - Extended moves reach only 256-byte on-chip RAM
`timescale 1ns/1ps
`include "cil_defs.svh"

module cil_decoder (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        op_valid,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  acc_in,
    input  wire logic [7:0]  b_in,
    input  wire logic [7:0]  ri_in,
    input  wire logic [15:0] data_pointer,
    output logic             busy,
    output logic [1:0]       instr_bytes,
    output logic [3:0]       instr_cycles,
    output logic             fetch_next,
    output logic             read_latch,
    output logic             xram_sel,
    output logic [7:0]       xram_addr,
    output logic             xram_wrap,
    output logic [7:0]       acc_out,
    output logic [7:0]       b_out,
    output logic             arith_excess_flag,
    output logic             muldiv_done
);

    // Builds one table entry
    function automatic cil_pkg::cil_info_type mk(input logic [1:0] b, input logic [3:0] c);
        cil_pkg::cil_info_type r;
        r.bytes  = b;
        r.cycles = c;
        return r;
    endfunction

    // Length and cycle table, indexed by opcode columns
    // The low nibble picks the operand column and the high nibble the operation
    // Reserved and unlisted codes fall back to one byte and one cycle
    function automatic cil_pkg::cil_info_type decode(input logic [7:0] op);
        cil_pkg::cil_info_type r;  // Entry being built
        logic [3:0]            hi; // Operation row
        logic [3:0]            lo; // Operand column
        hi = op[7:4];
        lo = op[3:0];
        r  = mk(2'h1, 4'h1);
        if (lo >= 4'h8) begin
            // Working register column
            unique case (hi)
                // Immediate into register, moves between register and direct byte
                4'h7, 4'h8, 4'hA: r = mk(2'h2, 4'h2);
                // Compare register with immediate, branch
                4'hB:             r = mk(2'h3, 4'h4);
                // Decrement register, branch
                4'hD:             r = mk(2'h2, 4'h3);
                // Exchange and moves between register and accumulator
                4'hC, 4'hE, 4'hF: r = mk(2'h1, 4'h1);
                // Register arithmetic, logic, increment, decrement
                default:          r = mk(2'h1, 4'h1);
            endcase
        end else if (lo >= 4'h6) begin
            // Indirect pointer column
            unique case (hi)
                // Immediate into indirect, moves between indirect and direct byte
                4'h7, 4'h8, 4'hA: r = mk(2'h2, 4'h2);
                // Compare indirect with immediate, branch
                4'hB:             r = mk(2'h3, 4'h4);
                // Whole and nibble exchange with indirect memory
                4'hC, 4'hD:       r = mk(2'h1, 4'h2);
                // Moves between accumulator and indirect memory
                4'hE, 4'hF:       r = mk(2'h1, 4'h2);
                // Indirect arithmetic, logic, increment, decrement
                default:          r = mk(2'h1, 4'h2);
            endcase
        end else begin
            unique case (lo)
                // Bit jumps, pointer load, carry bit ops, stack, pointer moves
                4'h0: begin
                    unique case (hi)
                        // No operation
                        4'h0:             r = mk(2'h1, 4'h1);
                        // Jumps on a direct bit, with or without clearing it
                        4'h1, 4'h2, 4'h3: r = mk(2'h3, 4'h4);
                        // Sixteen-bit data pointer load
                        4'h9:             r = mk(2'h3, 4'h3);
                        // Inverted bit into carry
                        4'hA, 4'hB:       r = mk(2'h2, 4'h2);
                        // Push and pop
                        4'hC, 4'hD:       r = mk(2'h2, 4'h2);
                        // Extended moves through the data pointer
                        4'hE, 4'hF:       r = mk(2'h1, 4'h4);
                        // Carry, zero and short relative jumps
                        default:          r = mk(2'h2, 4'h3);
                    endcase
                end
                // Absolute calls and jumps
                4'h1: r = mk(2'h2, 4'h3);
                // Long transfers, returns, accumulator into direct, bit ops
                4'h2: begin
                    unique case (hi)
                        // Long jump and long call
                        4'h0, 4'h1:       r = mk(2'h3, 4'h4);
                        // Returns
                        4'h2, 4'h3:       r = mk(2'h1, 4'h4);
                        // Accumulator logic into a direct byte
                        4'h4, 4'h5, 4'h6: r = mk(2'h2, 4'h2);
                        // Extended moves through the first register pointer
                        4'hE, 4'hF:       r = mk(2'h1, 4'h4);
                        // Direct bit operations
                        default:          r = mk(2'h2, 4'h2);
                    endcase
                end
                // Rotates, immediate into direct, table jump and loads, carry ops
                4'h3: begin
                    unique case (hi)
                        // Immediate logic into a direct byte
                        4'h4, 4'h5, 4'h6: r = mk(2'h3, 4'h3);
                        // Indirect table jump
                        4'h7:             r = mk(2'h1, 4'h3);
                        // Code byte loads
                        4'h8, 4'h9:       r = mk(2'h1, 4'h4);
                        // Data pointer increment
                        4'hA:             r = mk(2'h1, 4'h3);
                        // Extended moves through the second register pointer
                        4'hE, 4'hF:       r = mk(2'h1, 4'h4);
                        // Rotates and carry-only operations
                        default:          r = mk(2'h1, 4'h1);
                    endcase
                end
                // Accumulator-only and immediate accumulator column
                4'h4: begin
                    unique case (hi)
                        // Increment, decrement, swap, clear, complement
                        4'h0, 4'h1, 4'hC, 4'hE, 4'hF: r = mk(2'h1, 4'h1);
                        // Multiply and divide, the long fixed sequences
                        4'h8, 4'hA:       r = mk(2'h1, `CIL_MULDIV_CYC);
                        // Compare accumulator with immediate, branch
                        4'hB:             r = mk(2'h3, 4'h4);
                        // Decimal adjust
                        4'hD:             r = mk(2'h1, 4'h2);
                        // Immediate operand into the accumulator
                        default:          r = mk(2'h2, 4'h2);
                    endcase
                end
                default: begin
                    // Direct byte column
                    unique case (hi)
                        // Direct increment and decrement
                        4'h0, 4'h1:       r = mk(2'h2, 4'h2);
                        // Immediate into direct, direct to direct
                        4'h7, 4'h8:       r = mk(2'h3, 4'h3);
                        // Reserved code, run as a one-cycle no-op
                        4'hA:             r = mk(2'h1, 4'h1);
                        // Compare accumulator with direct, branch
                        4'hB:             r = mk(2'h3, 4'h4);
                        // Decrement direct byte, branch
                        4'hD:             r = mk(2'h3, 4'h4);
                        // Direct operand with the accumulator
                        default:          r = mk(2'h2, 4'h2);
                    endcase
                end
            endcase
        end
        return r;
    endfunction

    // Opcodes whose destination byte or bit is read back from the latch
    // Reading the pin instead could see a loaded output at the wrong level
    // Flagged per opcode; whether the target is a port is the caller's check
    function automatic logic is_rmw(input logic [7:0] op);
        unique case (op)
            8'h10, 8'h05, 8'h15, 8'hD5, 8'h42, 8'h43, 8'h52, 8'h53,
            8'h62, 8'h63, 8'h92, 8'hB2, 8'hC2, 8'hD2: is_rmw = 1'b1;
            default:                                  is_rmw = 1'b0;
        endcase
    endfunction

    cil_pkg::cil_regs_type s_q;     // Registered state
    cil_pkg::cil_regs_type s_d;     // Next state
    cil_pkg::cil_info_type info;    // Decoded current opcode
    logic [15:0]           product; // Full multiply result
    logic                  take;    // Opcode accepted this cycle

    // Next-state logic
    // Side outputs are captured at acceptance, so the core may use them early
    always_comb begin
        info       = decode(opcode);
        // Both factors widened so the full product survives
        product    = {8'h00, acc_in} * {8'h00, b_in};
        take       = op_valid && (s_q.state == cil_pkg::CIL_IDLE);
        s_d        = s_q;
        s_d.fetch_next  = 1'b0;
        s_d.muldiv_done = 1'b0;
        unique case (s_q.state)
            cil_pkg::CIL_IDLE: begin
                // Requests while busy are never seen here; they are dropped, not queued
                if (take) begin
                    s_d.bytes      = info.bytes;
                    s_d.cycles     = info.cycles;
                    s_d.read_latch = is_rmw(opcode);
                    s_d.xram_sel   = (opcode[7:5] == 3'b111) && (opcode[3:2] == 2'b00)
                                     && (opcode[1] ^ ~opcode[0] ? 1'b1 : opcode[1]);
                    // Only the low byte of the pointer is used; high byte flagged
                    if (opcode == `CIL_OP_XMOVE_PTR_RD || opcode == `CIL_OP_XMOVE_PTR_WR) begin
                        s_d.xram_addr = data_pointer[7:0];
                        s_d.xram_wrap = (data_pointer > `CIL_XRAM_TOP);
                    end else begin
                        s_d.xram_addr = ri_in;
                        s_d.xram_wrap = 1'b0;
                    end
                    if (opcode == `CIL_OP_MUL) begin
                        s_d.acc_out = product[7:0];
                        s_d.b_out   = product[15:8];
                        s_d.excess  = (product[15:8] != 8'h00);
                    end else if (opcode == `CIL_OP_DIV) begin
                        // Zero divisor gives quotient FF and the dividend as remainder
                        s_d.excess  = (b_in == 8'h00);
                        s_d.acc_out = (b_in == 8'h00) ? 8'hFF : acc_in / b_in;
                        s_d.b_out   = (b_in == 8'h00) ? acc_in : acc_in % b_in;
                    end
                    // One-cycle opcodes keep the core at full rate
                    if (info.cycles == 4'h1) begin
                        s_d.fetch_next = 1'b1;
                        s_d.busy       = 1'b0;
                    end else begin
                        s_d.state  = cil_pkg::CIL_EXEC;
                        // Cycle 1 follows at once; count the rest down to zero
                        s_d.remain = info.cycles - 4'h2;
                        s_d.busy   = 1'b1;
                    end
                end
            end
            cil_pkg::CIL_EXEC: begin
                // Count down the remaining cycles of the instruction
                if (s_q.remain == 4'h0) begin
                    // Last cycle: hand the fetch back in the very next one
                    s_d.state      = cil_pkg::CIL_IDLE;
                    s_d.busy       = 1'b0;
                    s_d.fetch_next = 1'b1;
                    s_d.muldiv_done = (s_q.cycles == `CIL_MULDIV_CYC);
                end else begin
                    s_d.remain = s_q.remain - 4'h1;
                end
            end
            default: begin
                // Illegal code recovers to idle
                s_d.state = cil_pkg::CIL_IDLE;
                s_d.busy  = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Idle entry reads as a one-byte, one-cycle opcode
            s_q        <= '0;
            s_q.state  <= cil_pkg::CIL_IDLE;
            s_q.bytes  <= `CIL_RST_BYTES;
            s_q.cycles <= `CIL_RST_CYCLES;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign busy              = s_q.busy;
    assign instr_bytes       = s_q.bytes;
    assign instr_cycles      = s_q.cycles;
    assign fetch_next        = s_q.fetch_next;
    assign read_latch        = s_q.read_latch;
    assign xram_sel          = s_q.xram_sel;
    assign xram_addr         = s_q.xram_addr;
    assign xram_wrap         = s_q.xram_wrap;
    assign acc_out           = s_q.acc_out;
    assign b_out             = s_q.b_out;
    assign arith_excess_flag = s_q.excess;
    assign muldiv_done       = s_q.muldiv_done;

endmodule // cil_decoder

// [test/cil_decoder_chk.sv]
// Port-level assertions for the instruction length and cycle decoder
`timescale 1ns/1ps
module cil_decoder_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        op_valid,
    input wire logic [7:0]  opcode,
    input wire logic [7:0]  acc_in,
    input wire logic [7:0]  b_in,
    input wire logic [7:0]  ri_in,
    input wire logic [15:0] data_pointer,
    input wire logic        busy,
    input wire logic [1:0]  instr_bytes,
    input wire logic [3:0]  instr_cycles,
    input wire logic        fetch_next,
    input wire logic        read_latch,
    input wire logic        xram_sel,
    input wire logic [7:0]  xram_addr,
    input wire logic        xram_wrap,
    input wire logic [7:0]  acc_out,
    input wire logic [7:0]  b_out,
    input wire logic        arith_excess_flag,
    input wire logic        muldiv_done
);
    logic [3:0] cnt_q;                     // Cycle number of the running opcode
    wire        take = op_valid && !busy;  // Opcode accepted at this edge
    // Saturating count so a stale value never matches a later length
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) cnt_q <= 4'h0;
        else if (take) cnt_q <= 4'h1;
        else if (cnt_q != 4'h0 && cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    fetch_count_a: assert property (fetch_next |-> cnt_q == instr_cycles)
        else $error("fetch pulse off its cycle count");
    fetch_due_a: assert property (cnt_q != 4'h0 && cnt_q == instr_cycles |-> fetch_next)
        else $error("fetch pulse missing");
    busy_span_a: assert property (busy |-> cnt_q < instr_cycles)
        else $error("busy beyond last cycle");
    busy_start_a: assert property (take ##1 instr_cycles > 4'h1 |-> busy)
        else $error("busy not raised");
    ignore_busy_a: assert property (op_valid && busy |=> $stable(instr_cycles) && $stable(instr_bytes))
        else $error("opcode taken while busy");
    reg_alu_a: assert property (take && opcode == 8'h28 |=> instr_bytes == 2'h1 && fetch_next)
        else $error("register add not one byte one cycle");
    mul_result_a: assert property (take && opcode == 8'hA4 |=>
        {b_out, acc_out} == {8'h00, $past(acc_in)} * {8'h00, $past(b_in)})
        else $error("product halves wrong");
    div_zero_a: assert property (take && opcode == 8'h84 |=> arith_excess_flag == ($past(b_in) == 8'h00))
        else $error("divide excess flag wrong");
    xram_ptr_a: assert property (take && opcode == 8'hE0 |=> xram_sel && xram_addr == $past(data_pointer[7:0])
        && xram_wrap == ($past(data_pointer[15:8]) != 8'h00))
        else $error("pointer move address wrong");
    muldiv_len_a: assert property (muldiv_done |-> fetch_next && instr_cycles == 4'h9)
        else $error("done pulse misplaced");
    mul_c: cover property (take && opcode == 8'hA4);
    refuse_c: cover property (op_valid && busy);
    chain_c: cover property (fetch_next && take);
    div_zero_c: cover property (take && opcode == 8'h84 && b_in == 8'h00);
endmodule // cil_decoder_chk

bind cil_decoder cil_decoder_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .opcode(opcode), .acc_in(acc_in), .b_in(b_in), .ri_in(ri_in), .data_pointer(data_pointer),
    .busy(busy), .instr_bytes(instr_bytes), .instr_cycles(instr_cycles), .fetch_next(fetch_next),
    .read_latch(read_latch), .xram_sel(xram_sel), .xram_addr(xram_addr), .xram_wrap(xram_wrap),
    .acc_out(acc_out), .b_out(b_out), .arith_excess_flag(arith_excess_flag), .muldiv_done(muldiv_done));

// [test/testbench.sv]
// Self-checking bench for the instruction length and cycle decoder
`timescale 1ns/1ps
`define CHK(what, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", what, e, g); end end
module testbench;
    logic sys_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0;   // Clock, reset, request
    logic [7:0] opcode = 8'h00, acc_in = 8'h00, b_in = 8'h00, ri_in = 8'h00;  // Operands
    logic [15:0] data_pointer = 16'h0000;                    // Pointer operand
    logic busy, fetch_next, read_latch, xram_sel, xram_wrap, arith_excess_flag, muldiv_done;
    logic [1:0] instr_bytes;
    logic [3:0] instr_cycles;
    logic [7:0] xram_addr, acc_out, b_out;
    int err_count = 0, n_tests = 0;                          // Mismatches, comparisons
    // Opcode, bytes, cycles
    localparam logic [13:0] TBL [23] = '{
        {8'h28,2'h1,4'h1}, {8'h26,2'h1,4'h2}, {8'h24,2'h2,4'h2}, {8'h53,2'h3,4'h3},
        {8'hA3,2'h1,4'h3}, {8'h05,2'h2,4'h2}, {8'hE4,2'h1,4'h1}, {8'hE6,2'h1,4'h2},
        {8'h85,2'h3,4'h3}, {8'h90,2'h3,4'h3}, {8'h93,2'h1,4'h4}, {8'hE2,2'h1,4'h4},
        {8'hC0,2'h2,4'h2}, {8'hD6,2'h1,4'h2}, {8'hC3,2'h1,4'h1}, {8'h92,2'h2,4'h2},
        {8'h73,2'h1,4'h3}, {8'h80,2'h2,4'h3}, {8'h10,2'h3,4'h4}, {8'h02,2'h3,4'h4},
        {8'hB4,2'h3,4'h4}, {8'hD8,2'h2,4'h3}, {8'hD5,2'h3,4'h4}};
    cil_decoder i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid), .opcode(opcode),
        .acc_in(acc_in), .b_in(b_in), .ri_in(ri_in), .data_pointer(data_pointer), .busy(busy),
        .instr_bytes(instr_bytes), .instr_cycles(instr_cycles), .fetch_next(fetch_next),
        .read_latch(read_latch), .xram_sel(xram_sel), .xram_addr(xram_addr), .xram_wrap(xram_wrap),
        .acc_out(acc_out), .b_out(b_out), .arith_excess_flag(arith_excess_flag), .muldiv_done(muldiv_done));
    // 25 ns clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // One opcode, then watch nine cycles of busy and fetch
    task automatic run_op(input logic [7:0] op, a, b, r, input logic [15:0] dp,
                          input logic [1:0] nb, input logic [3:0] nc);
        @(posedge sys_clk);
        {op_valid, opcode, acc_in, b_in, ri_in, data_pointer} <= {1'b1, op, a, b, r, dp};
        for (int k = 1; k < 10; k++) begin
            @(posedge sys_clk);
            op_valid <= 1'b0;
            #1;
            if (k == 1) `CHK("length", {nb, nc}, {instr_bytes, instr_cycles})
            `CHK("fetch", k == nc, fetch_next)
            `CHK("busy", k < nc, busy)
            `CHK("done", k == nc && nc == 4'h9, muldiv_done)
        end
    endtask
    // 23 opcodes from the length table; no absolute jump, return or decimal adjust among them
    task automatic test_table();
        for (int i = 0; i < 23; i++) run_op(TBL[i][13:6], 8'h00, 8'h00, 8'h00, 16'h0000, TBL[i][5:4], TBL[i][3:0]);
        $display("test table done");
    endtask
    // Multiply and divide results and excess flag
    task automatic test_muldiv();
        run_op(8'hA4, 8'h20, 8'h10, 8'h00, 16'h0000, 2'h1, 4'h9);
        `CHK("mul", {1'b1, 16'h0200}, {arith_excess_flag, b_out, acc_out})
        run_op(8'hA4, 8'h0F, 8'h03, 8'h00, 16'h0000, 2'h1, 4'h9);
        `CHK("mul small", {1'b0, 16'h002D}, {arith_excess_flag, b_out, acc_out})
        run_op(8'h84, 8'h64, 8'h07, 8'h00, 16'h0000, 2'h1, 4'h9);
        `CHK("div", {1'b0, 16'h020E}, {arith_excess_flag, b_out, acc_out})
        run_op(8'h84, 8'h64, 8'h00, 8'h00, 16'h0000, 2'h1, 4'h9);
        `CHK("div zero", 1'b1, arith_excess_flag)
        $display("test muldiv done");
    endtask
    // Extended RAM addressing and latch reads
    task automatic test_side();
        run_op(8'hE2, 8'h00, 8'h00, 8'h5A, 16'hA5A5, 2'h1, 4'h4);
        `CHK("xram reg", 10'h2B4, {xram_sel, xram_addr, xram_wrap})
        run_op(8'hE0, 8'h00, 8'h00, 8'h00, 16'h0134, 2'h1, 4'h4);
        `CHK("xram wrap", 10'h269, {xram_sel, xram_addr, xram_wrap})
        run_op(8'hF0, 8'h00, 8'h00, 8'h00, 16'h00FF, 2'h1, 4'h4);
        `CHK("xram top", 10'h3FE, {xram_sel, xram_addr, xram_wrap})
        run_op(8'h28, 8'h00, 8'h00, 8'h00, 16'h0000, 2'h1, 4'h1);
        `CHK("plain", 2'h0, {xram_sel, read_latch})
        run_op(8'h53, 8'h00, 8'h00, 8'h00, 16'h0000, 2'h3, 4'h3);
        `CHK("latch logic", 1'b1, read_latch)
        run_op(8'hD5, 8'h00, 8'h00, 8'h00, 16'h0000, 2'h3, 4'h4);
        `CHK("latch branch", 1'b1, read_latch)
        $display("test side done");
    endtask
    // Request while busy is dropped; then single-cycle opcodes back to back
    task automatic test_chain();
        @(posedge sys_clk);
        {op_valid, opcode} <= {1'b1, 8'h73};
        @(posedge sys_clk);
        opcode <= 8'h28;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1 `CHK("ignored", 4'h3, instr_cycles)
        @(posedge sys_clk);
        {op_valid, opcode} <= {1'b1, 8'hE4};
        #1 `CHK("jump end", 1'b1, fetch_next)
        @(posedge sys_clk);
        opcode <= 8'hC3;
        #1 `CHK("clear acc", 5'h11, {fetch_next, instr_cycles})
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1 `CHK("clear carry", 5'h11, {fetch_next, instr_cycles})
        $display("test chain done");
    endtask
    // Reset in mid-multiply clears every output but the length, which reads one byte, one cycle; an opcode then runs normally
    task automatic test_reset();
        @(posedge sys_clk);
        {op_valid, opcode, acc_in, b_in} <= {1'b1, 8'hA4, 8'h20, 8'h10};
        repeat (2) @(posedge sys_clk);
        {op_valid, sys_rst} <= 2'h1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 `CHK("reset length", 6'h11, {instr_bytes, instr_cycles})
        `CHK("reset flags", 7'h00, {busy, fetch_next, read_latch, xram_sel, xram_wrap, arith_excess_flag, muldiv_done})
        `CHK("reset data", 24'h000000, {xram_addr, acc_out, b_out})
        run_op(8'hE6, 8'h00, 8'h00, 8'h00, 16'h0000, 2'h1, 4'h2);
        $display("test reset done");
    endtask
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog well past the expected run of some 400 cycles
    initial begin
        #40000;
        err_count++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_table();
        test_muldiv();
        test_side();
        test_chain();
        test_reset();
        print_verdict();
    end
endmodule // testbench
